/* File: core/sha_defs.vh */
// shared constants of the statistical engine: bin counts, recognizer slots, state codes, timing
`ifndef SHA_DEFS_VH
`define SHA_DEFS_VH

// =====================================================================
// sizes
`define SHA_N_BINS          11
`define SHA_N_TI            8
`define SHA_N_REC           3
`define SHA_REC_WORDS       6

// =====================================================================
// recognizer slots; the bank select picks normal or statistical settings
`define SHA_REC_QUAL        2'h0
`define SHA_REC_START       2'h1
`define SHA_REC_END         2'h2
`define SHA_REC_BANK_OFS    3'h3

// =====================================================================
// interval tracker states, one-hot
`define SHA_ST_IDLE         3'h1
`define SHA_ST_ARMED        3'h2
`define SHA_ST_TIMING       3'h4

// =====================================================================
// timing: the target state clock may be no faster than this period
`define SHA_CLK_PERIOD_NS   100
`define SHA_MIN_STCLK_NS    10
`define SHA_MIN_STCLK_CYC   (((`SHA_MIN_STCLK_NS + `SHA_CLK_PERIOD_NS - 1) / `SHA_CLK_PERIOD_NS) < 1 ? 1 : ((`SHA_MIN_STCLK_NS + `SHA_CLK_PERIOD_NS - 1) / `SHA_CLK_PERIOD_NS))

`endif

/* File: core/sha_sat_cnt.v */
// saturating event counter with synchronous clear
`timescale 1ns/1ps
`default_nettype none

module sha_sat_cnt #(
  parameter W = 32
) (
  input  wire         clk_i,
  input  wire         rst_b_i,
  input  wire         clr_i,
  input  wire         inc_i,
  output reg  [W-1:0] cnt_o
);

  // =====================================================================
  // counter
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
      cnt_o <= {W{1'b0}};
    else if (clr_i)
      cnt_o <= {W{1'b0}};
    else if (inc_i && (cnt_o != {W{1'b1}}))
      cnt_o <= cnt_o + {{(W-1){1'b0}}, 1'b1};
  end

endmodule // sha_sat_cnt

`default_nettype wire

/* File: core/sha_div.v */
// serial restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none

module sha_div #(
  parameter NW = 48,
  parameter DW = 32
) (
  input  wire          clk_i,
  input  wire          rst_b_i,
  input  wire          clr_i,
  input  wire          go_i,
  input  wire [NW-1:0] num_i,
  input  wire [DW-1:0] den_i,
  output reg           busy_o,
  output reg           done_o,
  output reg  [NW-1:0] quo_o
);

  localparam CNT_W = $clog2(NW + 1);
  localparam [CNT_W-1:0] STEPS = NW;

  reg [NW-1:0]    q_reg;
  reg [DW-1:0]    r_reg;
  reg [DW-1:0]    d_reg;
  reg [CNT_W-1:0] cnt_reg;
  wire [DW:0]     trial = {r_reg, q_reg[NW-1]};
  wire            fits  = (trial >= {1'b0, d_reg});
  wire [DW:0]     diff  = trial - {1'b0, d_reg};

  // =====================================================================
  // iteration
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      q_reg   <= {NW{1'b0}};
      r_reg   <= {DW{1'b0}};
      d_reg   <= {DW{1'b0}};
      cnt_reg <= {CNT_W{1'b0}};
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
      quo_o   <= {NW{1'b0}};
    end
    else
    begin
      done_o <= 1'b0;
      if (clr_i)
        busy_o <= 1'b0;
      else if (go_i && !busy_o)
      begin
        q_reg   <= num_i;
        r_reg   <= {DW{1'b0}};
        d_reg   <= den_i;
        cnt_reg <= STEPS;
        busy_o  <= 1'b1;
      end
      else if (busy_o)
      begin
        r_reg   <= fits ? diff[DW-1:0] : trial[DW-1:0];
        q_reg   <= {q_reg[NW-2:0], fits};
        cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
        if (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1})
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          // zero divisor never starts here; guard anyway with saturation
          quo_o  <= (d_reg == {DW{1'b0}}) ? {NW{1'b1}} : {q_reg[NW-2:0], fits};
        end
      end
    end
  end

endmodule // sha_div

`default_nettype wire

/* File: core/sha_stat_engine.v */
// statistical engine: state histogram bins and start/end time interval statistics
// Notes on behaviour
// - eleven state bins, each with low, high and enable, on one monitored label.
// - with qualification on, only samples matching the qualify pattern are binned.
// - a sample inside several overlapping enabled bins counts in every one.
// - per-bin counts plus a total of samples tallied into the bins.
// - an other count takes qualified samples outside every enabled bin.
// - other include/exclude is display only and never touches counts.
// - accumulation runs from start until stop or any setting change other than other include/exclude.
// - start and end patterns span all labels, with per-bit don't care.
// - timing runs from first start to first following end; restarts ignored.
// - each start/end pair is one sample, counted in every range holding it.
// - eight interval ranges, auto-ranged linearly or logarithmically between min and max.
// - a duration on a shared boundary counts only in the higher range.
// - max, min and average durations kept over all pairs, whatever the ranges.
// - interval total counts every pair, in a range or not.
// - without a start or end match no interval figure or count changes.
// - statistical recognizer settings kept apart from normal ones, hardware shared.
`timescale 1ns/1ps
`default_nettype none
`include "sha_defs.vh"

module sha_stat_engine #(
  parameter DATA_W = 32,
  parameter LBL_W  = 16,
  parameter CW     = 32,
  parameter TW     = 32,
  parameter SW     = 48
) (
  input  wire                          clk_i,
  input  wire                          rst_b_i,
  input  wire                          st_clk_i,
  input  wire [DATA_W-1:0]             st_data_i,
  input  wire                          run_i,
  input  wire                          stop_i,
  input  wire                          cfg_chg_i,
  input  wire                          statistical_perf_analysis_i,
  input  wire                          ti_mode_i,
  input  wire                          qual_en_i,
  input  wire [4:0]                    lbl_lsb_i,
  input  wire [`SHA_N_BINS*LBL_W-1:0]  bin_lo_i,
  input  wire [`SHA_N_BINS*LBL_W-1:0]  bin_hi_i,
  input  wire [`SHA_N_BINS-1:0]        bin_en_i,
  input  wire                          other_incl_i,
  input  wire                          rec_wr_i,
  input  wire [1:0]                    rec_sel_i,
  input  wire [DATA_W-1:0]             rec_val_i,
  input  wire [DATA_W-1:0]             rec_care_i,
  input  wire [`SHA_N_TI*TW-1:0]       ti_lo_i,
  input  wire [`SHA_N_TI*TW-1:0]       ti_hi_i,
  input  wire                          ti_load_i,
  input  wire                          auto_go_i,
  input  wire                          auto_log_i,
  input  wire [TW-1:0]                 auto_min_i,
  input  wire [TW-1:0]                 auto_max_i,
  output reg                           running_o,
  output reg  [`SHA_N_REC-1:0]         rec_match_o,
  output wire [`SHA_N_BINS*CW-1:0]     bin_cnt_o,
  output wire [CW-1:0]                 other_cnt_o,
  output reg                           other_show_o,
  output wire [CW-1:0]                 hist_total_o,
  output wire [`SHA_N_TI*CW-1:0]       ti_cnt_o,
  output wire [`SHA_N_TI*TW-1:0]       ti_lo_o,
  output wire [`SHA_N_TI*TW-1:0]       ti_hi_o,
  output wire [CW-1:0]                 ti_total_o,
  output reg  [TW-1:0]                 ti_max_o,
  output reg  [TW-1:0]                 ti_min_o,
  output reg  [TW-1:0]                 ti_avg_o,
  output reg                           ti_valid_o
);

  // =====================================================================
  // helpers
  function pat_hit;
    input [DATA_W-1:0] d;
    input [DATA_W-1:0] v;
    input [DATA_W-1:0] c;
    begin
      pat_hit = (((d ^ v) & c) == {DATA_W{1'b0}});
    end
  endfunction

  function [2:0] rec_idx;
    input       bank;
    input [1:0] sel;
    begin
      rec_idx = {1'b0, sel} + (bank ? `SHA_REC_BANK_OFS : 3'h0);
    end
  endfunction

  // linear: min + span*k/8; log: min at k=0, else min + span/2^(8-k), so the top edge is max
  function [TW-1:0] auto_bnd;
    input [3:0]    k;
    input [TW-1:0] mn;
    input [TW-1:0] sp;
    input          lg;
    reg   [TW+3:0] prod;
    reg   [TW-1:0] off;
    begin
      prod = {4'h0, sp} * k;
      if (lg)
        off = (k == 4'h0) ? {TW{1'b0}} : (sp >> (`SHA_N_TI - k));
      else
        off = prod[TW+2:3];
      auto_bnd = mn + off;
    end
  endfunction

  // =====================================================================
  // target bus capture; state clock is only a sampled level here
  reg              st_clk_s1_reg;
  reg              st_clk_s2_reg;
  reg              st_clk_s3_reg;
  reg [DATA_W-1:0] data_s1_reg;
  reg [DATA_W-1:0] data_s2_reg;
  reg [TW-1:0]     tag_reg;
  wire             smp_edge = st_clk_s2_reg & ~st_clk_s3_reg;

  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      st_clk_s1_reg <= 1'b0;
      st_clk_s2_reg <= 1'b0;
      st_clk_s3_reg <= 1'b0;
      data_s1_reg   <= {DATA_W{1'b0}};
      data_s2_reg   <= {DATA_W{1'b0}};
      tag_reg       <= {TW{1'b0}};
    end
    else
    begin
      st_clk_s1_reg <= st_clk_i;
      st_clk_s2_reg <= st_clk_s1_reg;
      st_clk_s3_reg <= st_clk_s2_reg;
      data_s1_reg   <= st_data_i;
      data_s2_reg   <= data_s1_reg;
      // free-running time tag; durations are modular so wrap is harmless
      tag_reg       <= tag_reg + {{(TW-1){1'b0}}, 1'b1};
    end
  end

  // =====================================================================
  // run control
  reg  [7:0] cfg_reg;
  wire [7:0] cfg_now   = {statistical_perf_analysis_i, ti_mode_i, qual_en_i, lbl_lsb_i};
  // other_incl_i is deliberately absent: toggling it must not stop a run
  wire       cfg_event = (cfg_now != cfg_reg) | cfg_chg_i | rec_wr_i | ti_load_i | auto_go_i;
  wire       halt      = stop_i | cfg_event;
  wire       start_p   = run_i & ~halt & statistical_perf_analysis_i;

  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      cfg_reg      <= 8'h00;
      running_o    <= 1'b0;
      other_show_o <= 1'b0;
    end
    else
    begin
      cfg_reg      <= cfg_now;
      other_show_o <= other_incl_i;
      if (halt)
        running_o <= 1'b0;
      else if (start_p)
        running_o <= 1'b1;
    end
  end

  // =====================================================================
  // pattern recognizers: two setting banks, one comparator set
  reg  [DATA_W-1:0] rec_val_reg  [0:`SHA_REC_WORDS-1];
  reg  [DATA_W-1:0] rec_care_reg [0:`SHA_REC_WORDS-1];
  wire [2:0]        iq = rec_idx(statistical_perf_analysis_i, `SHA_REC_QUAL);
  wire [2:0]        is = rec_idx(statistical_perf_analysis_i, `SHA_REC_START);
  wire [2:0]        ie = rec_idx(statistical_perf_analysis_i, `SHA_REC_END);
  wire              qual_hit  = pat_hit(data_s2_reg, rec_val_reg[iq], rec_care_reg[iq]);
  wire              start_hit = pat_hit(data_s2_reg, rec_val_reg[is], rec_care_reg[is]);
  wire              end_hit   = pat_hit(data_s2_reg, rec_val_reg[ie], rec_care_reg[ie]);
  integer           n;

  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      for (n = 0; n < `SHA_REC_WORDS; n = n + 1)
      begin
        rec_val_reg[n]  <= {DATA_W{1'b0}};
        rec_care_reg[n] <= {DATA_W{1'b0}};
      end
      rec_match_o <= {`SHA_N_REC{1'b0}};
    end
    else
    begin
      if (rec_wr_i && (rec_sel_i <= `SHA_REC_END))
      begin
        rec_val_reg[rec_idx(statistical_perf_analysis_i, rec_sel_i)]  <= rec_val_i;
        rec_care_reg[rec_idx(statistical_perf_analysis_i, rec_sel_i)] <= rec_care_i;
      end
      rec_match_o <= {end_hit, start_hit, qual_hit};
    end
  end

  // =====================================================================
  // state histogram
  wire [DATA_W-1:0]      lbl_sh   = data_s2_reg >> lbl_lsb_i;
  wire [LBL_W-1:0]       lbl      = lbl_sh[LBL_W-1:0];
  wire                   hist_smp = smp_edge & running_o & ~ti_mode_i & (~qual_en_i | qual_hit);
  wire [`SHA_N_BINS-1:0] in_bin;

  genvar i;
  generate
    for (i = 0; i < `SHA_N_BINS; i = i + 1)
    begin : g_bin
      wire [LBL_W-1:0] lo = bin_lo_i[i*LBL_W +: LBL_W];
      wire [LBL_W-1:0] hi = bin_hi_i[i*LBL_W +: LBL_W];
      assign in_bin[i] = bin_en_i[i] & (lbl >= lo) & (lbl <= hi);
      sha_sat_cnt #(.W(CW)) u_cnt (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .clr_i   (start_p),
        .inc_i   (hist_smp & in_bin[i]),
        .cnt_o   (bin_cnt_o[i*CW +: CW])
      );
    end
  endgenerate

  sha_sat_cnt #(.W(CW)) u_other (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .clr_i   (start_p),
    .inc_i   (hist_smp & ~(|in_bin)),
    .cnt_o   (other_cnt_o)
  );

  sha_sat_cnt #(.W(CW)) u_htot (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .clr_i   (start_p),
    .inc_i   (hist_smp & (|in_bin)),
    .cnt_o   (hist_total_o)
  );

  // =====================================================================
  // interval tracker
  reg  [2:0]    ti_st_reg;
  reg  [TW-1:0] t0_reg;
  wire          ti_smp = smp_edge & running_o & ti_mode_i;
  wire          pair   = ti_smp & (ti_st_reg == `SHA_ST_TIMING) & end_hit;
  wire [TW-1:0] dur    = tag_reg - t0_reg;

  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      ti_st_reg <= `SHA_ST_IDLE;
      t0_reg    <= {TW{1'b0}};
    end
    else if (halt)
      ti_st_reg <= `SHA_ST_IDLE;
    else if (start_p)
      ti_st_reg <= `SHA_ST_ARMED;
    else if (ti_smp)
    begin
      case (ti_st_reg)
        `SHA_ST_IDLE:
          ti_st_reg <= `SHA_ST_IDLE;
        `SHA_ST_ARMED:
          if (start_hit)
          begin
            ti_st_reg <= `SHA_ST_TIMING;
            t0_reg    <= tag_reg;
          end
        `SHA_ST_TIMING:
          // further starts are ignored; only the end closes the pair
          if (end_hit)
            ti_st_reg <= `SHA_ST_ARMED;
        default:
          ti_st_reg <= `SHA_ST_IDLE;
      endcase
    end
  end

  // =====================================================================
  // interval ranges, host loaded or auto-ranged
  wire [TW-1:0] span = auto_max_i - auto_min_i;

  genvar k;
  generate
    for (k = 0; k < `SHA_N_TI; k = k + 1)
    begin : g_ti
      localparam [3:0] KK = k;
      reg [TW-1:0] lo_reg;
      reg [TW-1:0] hi_reg;
      always @(posedge clk_i)
      begin
        if (!rst_b_i)
        begin
          lo_reg <= {TW{1'b0}};
          hi_reg <= {TW{1'b0}};
        end
        else if (auto_go_i)
        begin
          lo_reg <= auto_bnd(KK, auto_min_i, span, auto_log_i);
          hi_reg <= auto_bnd(KK + 4'h1, auto_min_i, span, auto_log_i);
        end
        else if (ti_load_i)
        begin
          lo_reg <= ti_lo_i[k*TW +: TW];
          hi_reg <= ti_hi_i[k*TW +: TW];
        end
      end
      assign ti_lo_o[k*TW +: TW] = lo_reg;
      assign ti_hi_o[k*TW +: TW] = hi_reg;
      sha_sat_cnt #(.W(CW)) u_cnt (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .clr_i   (start_p),
        // half-open range so a shared edge lands in the upper range
        .inc_i   (pair & (dur >= lo_reg) & (dur < hi_reg)),
        .cnt_o   (ti_cnt_o[k*CW +: CW])
      );
    end
  endgenerate

  sha_sat_cnt #(.W(CW)) u_ttot (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .clr_i   (start_p),
    .inc_i   (pair),
    .cnt_o   (ti_total_o)
  );

  // =====================================================================
  // duration statistics
  reg  [SW-1:0] sum_reg;
  reg           dirty_reg;
  wire [SW:0]   sum_add = {1'b0, sum_reg} + {{(SW-TW+1){1'b0}}, dur};
  wire          div_busy;
  wire          div_done;
  wire [SW-1:0] div_quo;
  wire          div_go  = dirty_reg & ~div_busy;

  always @(posedge clk_i)
  begin
    if (!rst_b_i || start_p)
    begin
      sum_reg    <= {SW{1'b0}};
      dirty_reg  <= 1'b0;
      ti_max_o   <= {TW{1'b0}};
      ti_min_o   <= {TW{1'b1}};
      ti_avg_o   <= {TW{1'b0}};
      ti_valid_o <= 1'b0;
    end
    else
    begin
      if (pair)
      begin
        sum_reg    <= sum_add[SW] ? {SW{1'b1}} : sum_add[SW-1:0];
        ti_valid_o <= 1'b1;
        if (dur > ti_max_o)
          ti_max_o <= dur;
        if (dur < ti_min_o)
          ti_min_o <= dur;
      end
      // a new pair while a division starts keeps the request pending
      if (pair)
        dirty_reg <= 1'b1;
      else if (div_go)
        dirty_reg <= 1'b0;
      if (div_done)
        ti_avg_o <= (|div_quo[SW-1:TW]) ? {TW{1'b1}} : div_quo[TW-1:0];
    end
  end

  // average lags the last pair by about SW cycles
  sha_div #(.NW(SW), .DW(CW)) u_div (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .clr_i   (start_p),
    .go_i    (div_go),
    .num_i   (sum_reg),
    .den_i   (ti_total_o),
    .busy_o  (div_busy),
    .done_o  (div_done),
    .quo_o   (div_quo)
  );

endmodule // sha_stat_engine

`default_nettype wire

/* File: dv/sha_stat_monitor.sv */
// assertion checker for the statistical engine, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "sha_defs.vh"

module sha_stat_monitor #(
  parameter CW = 32,
  parameter TW = 32
) (
  input wire logic          clk_i,
  input wire logic          rst_b_i,
  input wire logic          st_clk_i,
  input wire logic          run_i,
  input wire logic          stop_i,
  input wire logic          cfg_chg_i,
  input wire logic          statistical_perf_analysis_i,
  input wire logic          ti_mode_i,
  input wire logic          qual_en_i,
  input wire logic [4:0]    lbl_lsb_i,
  input wire logic          other_incl_i,
  input wire logic          rec_wr_i,
  input wire logic          ti_load_i,
  input wire logic          auto_go_i,
  input wire logic          running_o,
  input wire logic          other_show_o,
  input wire logic [CW-1:0] hist_total_o,
  input wire logic [CW-1:0] ti_total_o,
  input wire logic [TW-1:0] ti_max_o,
  input wire logic [TW-1:0] ti_min_o,
  input wire logic          ti_valid_o
);
  // =========
  // helper logic
  logic [7:0] watch_q;
  logic       st_q;
  logic [3:0] since_rise;
  wire  [7:0] watch  = {statistical_perf_analysis_i, ti_mode_i, qual_en_i, lbl_lsb_i};
  // snapshot clears to zero like the engine's, so the first cycle agrees
  wire        cfg_ev = (watch != watch_q) | cfg_chg_i | rec_wr_i | ti_load_i | auto_go_i;
  wire        run_ok = run_i && statistical_perf_analysis_i && !stop_i && !cfg_ev;

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      watch_q    <= 8'h00;
      st_q       <= 1'b0;
      since_rise <= 4'hF;
    end
    else
    begin
      watch_q <= watch;
      st_q    <= st_clk_i;
      if (st_clk_i && !st_q)
        since_rise <= 4'h0;
      else if (since_rise != 4'hF)
        since_rise <= since_rise + 4'h1;
    end
  end

  // =========
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence run_taken;
    run_ok;
  endsequence

  sequence idle_two;
    !running_o && !$past(running_o) && !$past(running_o, 2) && !run_ok;
  endsequence

  chk_run_start: assert property (run_taken |=> running_o && hist_total_o == '0
    && ti_total_o == '0) else $error("run start did not clear and run");
  chk_stop_halts: assert property (stop_i |=> !running_o)
    else $error("stop did not halt");
  chk_cfg_halts: assert property (cfg_ev |=> !running_o)
    else $error("setting change did not halt");
  chk_other_keep: assert property ($changed(other_incl_i) && running_o && !stop_i && !cfg_ev
    |=> running_o && other_show_o == $past(other_incl_i)) else $error("other toggle disturbed run");
  chk_idle_hold: assert property (idle_two |=> $stable(hist_total_o) && $stable(ti_total_o))
    else $error("counts moved while stopped");
  chk_total_sat: assert property ((&hist_total_o) && !run_ok |=> &hist_total_o)
    else $error("total left saturation");
  chk_total_step: assert property (running_o && !run_ok |=> hist_total_o == $past(hist_total_o)
    || hist_total_o == CW'($past(hist_total_o) + 1'b1)) else $error("total stepped wrongly");
  chk_sample_gap: assert property (running_o && $past(running_o) && !$past(run_ok)
    && ($changed(hist_total_o) || $changed(ti_total_o)) |-> since_rise inside {[1:5]})
    else $error("count changed without a state clock");
  chk_min_max: assert property (ti_valid_o |-> ti_min_o <= ti_max_o)
    else $error("minimum above maximum");
  chk_valid_total: assert property (ti_valid_o == (ti_total_o != '0))
    else $error("valid flag disagrees with pair total");
endmodule // sha_stat_monitor

bind sha_stat_engine sha_stat_monitor #(.CW(CW), .TW(TW)) u_mon (.*);
`default_nettype wire

/* File: dv/sha_tgt_model.sv */
// behavioural target bus: state clock and sampled data
`timescale 1ns/1ps
`default_nettype none

module sha_tgt_model #(
  parameter DATA_W = 32
) (
  input  wire logic              clk_i,
  output var  logic              st_clk_o,
  output var  logic [DATA_W-1:0] st_data_o
);
  initial
  begin
    st_clk_o  = 1'b0;
    st_data_o = '0;
  end

  // =========
  // one state clock: rises are 6+gap core clocks apart, far above the floor;
  // data is inverted after its hold so a late sampler cannot get lucky
  task automatic sample(input logic [DATA_W-1:0] v, input int gap);
    st_data_o = v;
    @(posedge clk_i);
    #1 st_clk_o = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 st_clk_o = 1'b0;
    @(posedge clk_i);
    #1 st_data_o = ~v;
    repeat (gap + 1) @(posedge clk_i);
    #1;
  endtask
endmodule // sha_tgt_model
`default_nettype wire

/* File: dv/test_sha_stat_engine.sv */
// self-checking bench for the statistical engine
`timescale 1ns/1ps
`default_nettype none
`include "sha_defs.vh"

module test_sha_stat_engine;
  localparam CW = 3;
  localparam TW = 32;
  localparam logic [31:0] ST_D = 32'h0000_1000;
  localparam logic [31:0] EN_D = 32'h0000_2000;
  logic clk_i = 1'b0, rst_b_i = 1'b0, run_i = 1'b0, stop_i = 1'b0, cfg_chg_i = 1'b0;
  logic statistical_perf_analysis_i = 1'b0, ti_mode_i = 1'b0;
  logic qual_en_i = 1'b0, other_incl_i = 1'b0;
  logic rec_wr_i = 1'b0, ti_load_i = 1'b0, auto_go_i = 1'b0, auto_log_i = 1'b0;
  logic [4:0] lbl_lsb_i = 5'h04;
  logic [1:0] rec_sel_i = 2'h0;
  logic [31:0] rec_val_i = '0, rec_care_i = '0, auto_min_i = '0, auto_max_i = '0;
  logic [175:0] bin_lo_i, bin_hi_i;
  logic [10:0] bin_en_i = 11'h5FF;
  logic [8*TW-1:0] ti_lo_i = '0, ti_hi_i = '0, ti_lo_o, ti_hi_o;
  logic st_clk_i, running_o, other_show_o, ti_valid_o;
  logic [31:0] st_data_i, ti_max_o, ti_min_o, ti_avg_o;
  logic [2:0] rec_match_o;
  logic [11*CW-1:0] bin_cnt_o;
  logic [8*CW-1:0] ti_cnt_o;
  logic [CW-1:0] other_cnt_o, hist_total_o, ti_total_o;
  int err_total = 0, cmp_count = 0, n;
  int exp_bin [11] = '{default: 0};
  int exp_tot = 0, exp_oth = 0;
  logic [15:0] row_lbl [8] = '{16'h0000, 16'h00FF, 16'h0100, 16'h0181,
                               16'h0900, 16'h0A00, 16'h08FF, 16'hFFFF};
  logic [10:0] row_hit [8] = '{11'h001, 11'h401, 11'h402, 11'h002,
                               11'h000, 11'h000, 11'h100, 11'h000};

  always #50 clk_i = ~clk_i;

  sha_tgt_model u_tgt (.clk_i(clk_i), .st_clk_o(st_clk_i), .st_data_o(st_data_i));

  sha_stat_engine #(.CW(CW), .SW(33)) u_dut (.*);

  // =========
  // helpers
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int k = 1);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic go_run;
    run_i = 1'b1;
    tick();
    run_i = 1'b0;
    tick();
  endtask

  task automatic rec_w(input logic [1:0] s, input logic [31:0] v, input logic [31:0] c);
    rec_sel_i = s;
    rec_val_i = v;
    rec_care_i = c;
    rec_wr_i = 1'b1;
    tick();
    rec_wr_i = 1'b0;
    tick();
  endtask

  task automatic auto_rng(input logic lg, input logic [31:0] mx);
    auto_log_i = lg;
    auto_max_i = mx;
    auto_go_i = 1'b1;
    tick();
    auto_go_i = 1'b0;
    tick();
  endtask

  task automatic chk_rng(input int step);
    for (int k = 0; k < 8; k++)
    begin
      check(ti_lo_o[k*TW +: TW], 32'(k * step), "range low");
      check(ti_hi_o[k*TW +: TW], 32'((k + 1) * step), "range high");
    end
  endtask

  function automatic logic [CW-1:0] bin_at(input int i);
    return bin_cnt_o[i*CW +: CW];
  endfunction

  function automatic logic [CW-1:0] ti_at(input int k);
    return ti_cnt_o[k*CW +: CW];
  endfunction

  initial
  begin
    #1_000_000;
    err_total++;
    summarize();
  end

  // =========
  // main sequence
  initial
  begin
    for (int i = 0; i < 11; i++)
    begin
      bin_lo_i[i*16 +: 16] = 16'(i << 8);
      bin_hi_i[i*16 +: 16] = 16'(i << 8) | 16'h00FF;
    end
    bin_lo_i[160 +: 16] = 16'h0080;
    bin_hi_i[160 +: 16] = 16'h0180;
    tick(5);
    rst_b_i = 1'b1;
    tick();
    check(running_o, 1'b0, "running after reset");
    check(ti_min_o, 32'hFFFF_FFFF, "min after reset");
    check(ti_valid_o, 1'b0, "valid after reset");
    go_run();
    check(running_o, 1'b0, "run in normal mode");
    statistical_perf_analysis_i = 1'b1;
    tick(2);
    go_run();
    check(running_o, 1'b1, "run started");
    for (int r = 0; r < 8; r++)
    begin
      u_tgt.sample({12'h0BC, row_lbl[r], 4'h5}, 0);
      for (int i = 0; i < 11; i++)
        exp_bin[i] += row_hit[r][i];
      if (row_hit[r] != 11'h000) exp_tot++;
      else exp_oth++;
      for (int i = 0; i < 11; i++)
        check(bin_at(i), exp_bin[i], "bin count");
      check(hist_total_o, exp_tot, "histogram total");
      check(other_cnt_o, exp_oth, "other count");
    end
    other_incl_i = 1'b1;
    tick(2);
    check(running_o, 1'b1, "running after other toggle");
    check(other_show_o, 1'b1, "other shown");
    check(other_cnt_o, 3'h3, "other kept");
    repeat (8) u_tgt.sample({12'h0BC, 16'h0010, 4'h5}, 0);
    check(bin_at(0), 3'h7, "bin saturates");
    check(hist_total_o, 3'h7, "total saturates");
    stop_i = 1'b1;
    tick();
    stop_i = 1'b0;
    tick();
    check(running_o, 1'b0, "stopped");
    u_tgt.sample({12'h0BC, 16'h0100, 4'h5}, 0);
    check(bin_at(1), 3'h2, "no count after stop");
    // qualified run; a bank-0 pattern must not leak into the statistical bank
    qual_en_i = 1'b1;
    rec_w(2'h0, 32'h8000_0000, 32'h8000_0000);
    statistical_perf_analysis_i = 1'b0;
    rec_w(2'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    statistical_perf_analysis_i = 1'b1;
    tick(2);
    go_run();
    u_tgt.sample({12'h0BC, 16'h0000, 4'h5}, 0);
    u_tgt.sample({12'h8BC, 16'h0000, 4'h5}, 0);
    u_tgt.sample({12'h0BC, 16'hFFFF, 4'h5}, 0);
    check(bin_at(0), 3'h1, "qualified bin");
    check(other_cnt_o, 3'h0, "unqualified not other");
    cfg_chg_i = 1'b1;
    tick();
    cfg_chg_i = 1'b0;
    tick();
    check(running_o, 1'b0, "halt on setting change");
    qual_en_i = 1'b0;
    ti_mode_i = 1'b1;
    rec_w(2'h1, ST_D, 32'hFFFF_FFFF);
    rec_w(2'h2, EN_D, 32'hFFFF_FFFF);
    auto_rng(1'b0, 32'd80);
    chk_rng(10);
    go_run();
    u_tgt.sample(EN_D, 2);
    check(ti_total_o, 3'h0, "end alone");
    check(ti_valid_o, 1'b0, "no interval yet");
    u_tgt.sample(ST_D, 4);
    u_tgt.sample(EN_D, 0);
    check(rec_match_o, 3'h4, "end match only");
    u_tgt.sample(ST_D, 0);
    u_tgt.sample(ST_D, 0);
    u_tgt.sample(EN_D, 0);
    u_tgt.sample(ST_D, 0);
    u_tgt.sample(EN_D, 0);
    u_tgt.sample(ST_D, 80);
    u_tgt.sample(EN_D, 0);
    check(ti_at(0), 3'h1, "range 0");
    check(ti_at(1), 3'h2, "range 1 boundary and restart");
    for (int k = 2; k < 8; k++)
      check(ti_at(k), 3'h0, "upper ranges");
    check(ti_total_o, 3'h4, "pair total");
    check(ti_max_o, 32'd86, "max");
    check(ti_min_o, 32'd6, "min");
    check(hist_total_o, 3'h0, "histogram idle in interval mode");
    for (n = 0; n < 200 && ti_avg_o !== 32'd28; n++)
      tick();
    check(ti_avg_o, 32'd28, "average");
    if (n == 200) summarize();
    auto_rng(1'b1, 32'd256);
    for (int k = 0; k < 8; k++)
    begin
      check(ti_lo_o[k*TW +: TW], (k == 0) ? 32'd0 : 32'd256 >> (8 - k), "log low");
      check(ti_hi_o[k*TW +: TW], 32'd256 >> (7 - k), "log high");
    end
    for (int k = 0; k < 8; k++)
    begin
      ti_lo_i[k*TW +: TW] = 32'(k * 5);
      ti_hi_i[k*TW +: TW] = 32'((k + 1) * 5);
    end
    ti_load_i = 1'b1;
    tick();
    ti_load_i = 1'b0;
    tick();
    chk_rng(5);
    summarize();
  end
endmodule // test_sha_stat_engine
`default_nettype wire
